// >>> rtl/rx_port_status_registers.sv
// Per-port receive status register bank with port-select routing
//
// Contract
// R1: Port select routes port-specific register accesses
// R2: Bit 7 set on unsteady line length
// R3: Bit 6 set on line length change
// R4: Bit 5 set on link coding fault
// R5: Software enables error counter, threshold above one; this bank has no error counter or threshold
// R6: Bit 4 set on packet buffer overflow
// R7: Bit 3 shows CSI receive error summary
// R8: Bit 2 shows frequency measurement settled
// R9: Bit 1 shows input clock missing
// R10: Bit 0 set on line count change
// R11: Frequency integer byte in MHz
// R12: Frequency fraction byte in 1/256 MHz
// R13: Sensor registers loaded from forward channel
// R14: Alarm flags register layout, reserved bits zero
// R15: Voltage levels register layout, reserved bits zero
// R16: Set wins over clear-on-read
`timescale 1ns/1ps
`include "rx_status_params.svh"
module rx_port_status_registers #(
	parameter int PORTS = 4
) (
	input  wire logic                                   clock,
	input  wire logic                                   arst_n,
	input  wire rx_status_pkg::reg_request_t            request,
	input  wire rx_status_pkg::port_events_t [PORTS-1:0] events,
	input  wire rx_status_pkg::port_levels_t [PORTS-1:0] levels,
	input  wire logic [PORTS-1:0]                       sensor_load,
	output logic [7:0]                                  rdata,
	output logic                                        rvalid
);
	import rx_status_pkg::*;

	localparam int SEL_W = (PORTS > 1) ? $clog2(PORTS) : 1;

	////////////////////////////////////////////////////////////////////////
	// Port select

	logic [SEL_W-1:0] port_select;
	logic [SEL_W-1:0] next_port_select;

	always_comb
	begin
		next_port_select = port_select;
		// Whole byte compared: a cut value would alias out-of-range writes onto real ports
		if (request.write && request.addr == `PORT_SELECT_OFFSET
			&& request.wdata < 8'(PORTS))
		begin
			next_port_select = request.wdata[SEL_W-1:0]; // R1
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			port_select <= '0;
		else
			port_select <= next_port_select;
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags and sensor copies

	logic [4:0] sticky      [PORTS];
	logic [4:0] next_sticky [PORTS];
	logic [5:0] alarms      [PORTS];
	logic [5:0] next_alarms [PORTS];
	logic [5:0] volts       [PORTS];
	logic [5:0] next_volts  [PORTS];

	function automatic logic [4:0] event_bits(input port_events_t e);
		event_bits = {e.line_length_unsteady, e.line_length_changed,
			e.link_coding_fault, e.buffer_error, e.line_count_changed};
	endfunction

	logic status_two_read;
	assign status_two_read = request.read && request.addr == `PORT_STATUS_TWO_OFFSET;

	always_comb
	begin
		for (int p = 0; p < PORTS; p++)
		begin
			next_sticky[p] = sticky[p];
			// Clear-on-read only reaches the selected port's copy
			if (status_two_read && port_select == SEL_W'(p))
				next_sticky[p] = '0; // R1
			// Event set after clear so a same-cycle event survives
			next_sticky[p] = next_sticky[p] | event_bits(events[p]); // R2 R3 R4 R6 R10 R16
			next_alarms[p] = alarms[p];
			next_volts[p]  = volts[p];
			// Loaded by the forward channel, never by software
			if (sensor_load[p])
			begin
				next_alarms[p] = levels[p].remote_alarms; // R13
				next_volts[p]  = {levels[p].remote_voltage_b_value,
					levels[p].remote_voltage_a_value}; // R13
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				sticky[p] <= '0;
				alarms[p] <= '0;
				volts[p]  <= '0;
			end
		end
		else
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				sticky[p] <= next_sticky[p];
				alarms[p] <= next_alarms[p];
				volts[p]  <= next_volts[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux, registered so outputs come from flip-flops

	logic [7:0] next_rdata;
	logic       next_rvalid;
	port_levels_t sel_lv;
	logic [4:0]   sel_st;

	always_comb
	begin
		sel_lv      = levels[port_select];
		sel_st      = sticky[port_select];
		next_rvalid = request.read;
		next_rdata  = `STATUS_RESET;
		if (request.read)
		begin
			unique case (request.addr)
				`PORT_SELECT_OFFSET:
					next_rdata = 8'(port_select);
				`PORT_STATUS_TWO_OFFSET:
				begin
					next_rdata[`BIT_LINE_LEN_UNSTEADY] = sel_st[4]; // R2
					next_rdata[`BIT_LINE_LEN_CHANGED]  = sel_st[3]; // R3
					next_rdata[`BIT_LINK_CODING_FAULT] = sel_st[2]; // R4
					next_rdata[`BIT_BUFFER_ERROR]      = sel_st[1]; // R6
					next_rdata[`BIT_CSI_ERROR]         = sel_lv.csi_error; // R7
					next_rdata[`BIT_FREQ_SETTLED]      = sel_lv.freq_measure_settled; // R8
					next_rdata[`BIT_CLOCK_MISSING]     = sel_lv.input_clock_missing; // R9
					next_rdata[`BIT_LINE_CNT_CHANGED]  = sel_st[0]; // R10
				end
				`FREQ_INTEGER_OFFSET:
					next_rdata = sel_lv.freq_integer_byte; // R11
				`FREQ_FRACTION_OFFSET:
					next_rdata = sel_lv.freq_fraction_byte; // R12
				`ALARM_FLAGS_OFFSET:
					next_rdata = {2'h0, alarms[port_select]}; // R14
				`VOLTAGE_LEVELS_OFFSET:
					next_rdata = {1'h0, volts[port_select][5:3],
						1'h0, volts[port_select][2:0]}; // R15
				default:
					next_rdata = `STATUS_RESET;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata  <= `STATUS_RESET;
			rvalid <= 1'b0;
		end
		else
		begin
			rdata  <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Register answers through the port select

	select_write_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		request.write && request.addr == `PORT_SELECT_OFFSET && request.wdata < 8'(PORTS)
		|=> port_select == $past(request.wdata[SEL_W-1:0]))
		else $error("port select not taken");
	select_refuse_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		request.write && request.addr == `PORT_SELECT_OFFSET && request.wdata >= 8'(PORTS)
		|=> port_select == $past(port_select))
		else $error("out of range port select taken");
	select_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		request.read && request.addr == `PORT_SELECT_OFFSET
		|=> rdata == 8'($past(port_select)))
		else $error("port select readback wrong");
	read_answer_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		request.read |=> rvalid)
		else $error("read not answered");
	idle_quiet_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		!request.read |=> !rvalid && rdata == `STATUS_RESET)
		else $error("read answer stood too long");

	// Status two shows the selected port's flags as they were before the clear
	sticky_route_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		status_two_read |=> {rdata[`BIT_LINE_LEN_UNSTEADY:`BIT_BUFFER_ERROR],
		rdata[`BIT_LINE_CNT_CHANGED]} == $past(sticky[port_select]))
		else $error("selected port flags not shown");
	csi_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R7
		status_two_read
		|=> rdata[`BIT_CSI_ERROR] == $past(levels[port_select].csi_error))
		else $error("csi error bit wrong");
	settled_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R8
		status_two_read
		|=> rdata[`BIT_FREQ_SETTLED] == $past(levels[port_select].freq_measure_settled))
		else $error("frequency settled bit wrong");
	status_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R9
		status_two_read |=> rvalid && rdata[`BIT_CLOCK_MISSING]
		== $past(levels[port_select].input_clock_missing))
		else $error("clock missing bit wrong");

	// Frequency bytes pass through from the selected port
	freq_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R11
		request.read && request.addr == `FREQ_INTEGER_OFFSET
		|=> rdata == $past(levels[port_select].freq_integer_byte))
		else $error("frequency integer wrong");
	fraction_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R12
		request.read && request.addr == `FREQ_FRACTION_OFFSET
		|=> rdata == $past(levels[port_select].freq_fraction_byte))
		else $error("frequency fraction wrong");

	// Sensor copies; reserved bits must read zero
	alarm_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R14
		request.read && request.addr == `ALARM_FLAGS_OFFSET
		|=> rdata[5:0] == $past(alarms[port_select]))
		else $error("alarm flags wrong");
	alarm_reserved_a: assert property (@(posedge clock) disable iff (!arst_n) // R14
		$past(request.read) && $past(request.addr) == `ALARM_FLAGS_OFFSET
		|-> rdata[7:6] == 2'h0)
		else $error("alarm reserved bits set");
	volt_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R15
		request.read && request.addr == `VOLTAGE_LEVELS_OFFSET
		|=> {rdata[6:4], rdata[2:0]} == $past(volts[port_select]))
		else $error("voltage levels wrong");
	volt_reserved_a: assert property (@(posedge clock) disable iff (!arst_n) // R15
		$past(request.read) && $past(request.addr) == `VOLTAGE_LEVELS_OFFSET
		|-> !rdata[7] && !rdata[3])
		else $error("voltage reserved bits set");

	// Per-port flag and sensor bookkeeping
	for (genvar p = 0; p < PORTS; p++)
	begin : per_port_checks
		// Each event sets its own flag, read or not
		unsteady_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
			events[p].line_length_unsteady |=> sticky[p][4])
			else $error("unsteady line length not flagged");
		length_change_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R3
			events[p].line_length_changed |=> sticky[p][3])
			else $error("line length change not flagged");
		coding_fault_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R4
			events[p].link_coding_fault |=> sticky[p][2])
			else $error("coding fault not flagged");
		buffer_error_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R6
			events[p].buffer_error |=> sticky[p][1])
			else $error("buffer overflow not flagged");
		count_change_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R10
			events[p].line_count_changed |=> sticky[p][0])
			else $error("line count change not flagged");

		// A same-cycle event must survive the clear
		event_survives_a: assert property (@(posedge clock) disable iff (!arst_n) // R16
			events[p] != '0 && status_two_read && port_select == SEL_W'(p)
			|=> (sticky[p] & $past(event_bits(events[p]))) == $past(event_bits(events[p])))
			else $error("event lost under clear");

		// Only the selected port's status read clears
		clear_on_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
			status_two_read && port_select == SEL_W'(p) && !(|event_bits(events[p]))
			|=> sticky[p] == 5'h00)
			else $error("flags not cleared by read");
		unread_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
			sticky[p][4] && !(status_two_read && port_select == SEL_W'(p))
			|=> sticky[p][4])
			else $error("unsteady flag dropped without read");
		other_port_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
			!(status_two_read && port_select == SEL_W'(p))
			|=> (sticky[p] & $past(sticky[p])) == $past(sticky[p]))
			else $error("flags cleared by another port's read");

		// Sensor copies change only on a forward channel load
		sensor_load_a: assert property (@(posedge clock) disable iff (!arst_n) // R13
			sensor_load[p] |=> alarms[p] == $past(levels[p].remote_alarms)
			&& volts[p] == $past({levels[p].remote_voltage_b_value,
			levels[p].remote_voltage_a_value}))
			else $error("sensor copy not loaded");
		sensor_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R13
			!sensor_load[p] |=> alarms[p] == $past(alarms[p]) && volts[p] == $past(volts[p]))
			else $error("sensor copy changed without a load");
	end
endmodule

// >>> include/rx_status_params.svh
// Offsets, field positions and reset values of the receive-port status bank
`ifndef RX_STATUS_PARAMS_SVH
`define RX_STATUS_PARAMS_SVH
`define PORT_SELECT_OFFSET     8'h4C
`define PORT_STATUS_ONE_OFFSET 8'h4D
`define PORT_STATUS_TWO_OFFSET 8'h4E
`define FREQ_INTEGER_OFFSET    8'h4F
`define FREQ_FRACTION_OFFSET   8'h50
`define ALARM_FLAGS_OFFSET     8'h51
`define VOLTAGE_LEVELS_OFFSET  8'h52
`define BIT_LINE_LEN_UNSTEADY  7
`define BIT_LINE_LEN_CHANGED   6
`define BIT_LINK_CODING_FAULT  5
`define BIT_BUFFER_ERROR       4
`define BIT_CSI_ERROR          3
`define BIT_FREQ_SETTLED       2
`define BIT_CLOCK_MISSING      1
`define BIT_LINE_CNT_CHANGED   0
`define STATUS_RESET           8'h00
`endif

// >>> include/rx_status_pkg.sv
// Types shared by the receive-port status bank
package rx_status_pkg;
	// Hardware events of one port, each a one-cycle pulse
	typedef struct packed {
		logic line_length_unsteady;
		logic line_length_changed;
		logic link_coding_fault;
		logic buffer_error;
		logic line_count_changed;
	} port_events_t;
	// Level status of one port
	typedef struct packed {
		logic       csi_error;
		logic       freq_measure_settled;
		logic       input_clock_missing;
		logic [7:0] freq_integer_byte;
		logic [7:0] freq_fraction_byte;
		logic [5:0] remote_alarms;
		logic [2:0] remote_voltage_b_value;
		logic [2:0] remote_voltage_a_value;
	} port_levels_t;
	// Register access request
	typedef struct packed {
		logic       read;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_request_t;
endpackage

// >>> bench/remote_serializer_model.sv
// Remote serializer model feeding sensor status over the forward channel
`timescale 1ns/1ps
module remote_serializer_model (
	input  wire logic                              clock,
	input  wire logic                              send,
	input  wire logic [1:0]                        port,
	input  wire logic [11:0]                       frame,
	input  wire rx_status_pkg::port_levels_t [3:0] base,
	output rx_status_pkg::port_levels_t [3:0]      levels,
	output logic [3:0]                             sensor_load
);
	import rx_status_pkg::*;
	logic [3:0][11:0] hold = '0;
	always @(posedge clock)
	begin
		sensor_load <= send ? 4'h1 << port : 4'h0;
		if (send)
			hold[port] <= frame;
	end
	// Sensor fields are garbage off the load pulse, so a late sample shows up
	always_comb
		for (int p = 0; p < 4; p++)
		begin
			levels[p] = base[p];
			{levels[p].remote_alarms, levels[p].remote_voltage_b_value,
				levels[p].remote_voltage_a_value} = sensor_load[p] ? hold[p] : ~hold[p];
		end
endmodule

// >>> bench/tb_rx_port_status_registers.sv
// Testbench of the receive-port status register bank
`timescale 1ns/1ps
`include "rx_status_params.svh"
module tb_rx_port_status_registers;
	import rx_status_pkg::*;
	logic               clock;
	logic               arst_n;
	reg_request_t       request;
	port_events_t [3:0] events;
	port_levels_t [3:0] base;
	port_levels_t [3:0] levels;
	logic [3:0]         sensor_load;
	logic               send;
	logic [1:0]         port;
	logic [11:0]        frame;
	logic [7:0]         rdata;
	logic               rvalid;
	int                 num_errors = 0;
	int                 total_checks = 0;
	rx_port_status_registers #(.PORTS(4)) rx_port_status_registers_i (.clock(clock),
		.arst_n(arst_n), .request(request), .events(events), .levels(levels),
		.sensor_load(sensor_load), .rdata(rdata), .rvalid(rvalid));
	remote_serializer_model remote_serializer_model_i (.clock(clock), .send(send),
		.port(port), .frame(frame), .base(base), .levels(levels), .sensor_load(sensor_load));
	////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
		@(negedge clock);
		request = '{read: rd, write: ~rd, addr: addr, wdata: wdata};
		@(negedge clock);
		request = '0;
	endtask
	task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp);
		access(1'b1, addr, 8'h00);
		check("rvalid", 8'h01, {7'h00, rvalid});
		check($sformatf("rdata at %h", addr), exp, rdata);
	endtask
	task automatic pulse(input int p, input port_events_t ev);
		@(negedge clock);
		events[p] = ev;
		@(negedge clock);
		events = '0;
	endtask
	////////////////////////////////////////
	task automatic sticky_flags;
		int pos[5] = '{0, 4, 5, 6, 7};
		access(1'b0, `PORT_SELECT_OFFSET, 8'h02);
		for (int i = 0; i < 5; i++)
		begin
			pulse(2, port_events_t'(5'h01 << i));
			read_reg(`PORT_STATUS_TWO_OFFSET, 8'h01 << pos[i]);
			read_reg(`PORT_STATUS_TWO_OFFSET, 8'h00);
		end
		pulse(2, 5'h1F);
		access(1'b0, `PORT_SELECT_OFFSET, 8'h00);
		read_reg(`PORT_STATUS_TWO_OFFSET, 8'h00);
		access(1'b0, `PORT_SELECT_OFFSET, 8'h02);
		read_reg(`PORT_STATUS_TWO_OFFSET, 8'hF1);
	endtask
	// Event lands in the very cycle the read clears
	task automatic set_wins;
		@(negedge clock);
		events[2] = 5'h10;
		request = '{read: 1'b1, write: 1'b0, addr: `PORT_STATUS_TWO_OFFSET, wdata: 8'h00};
		@(negedge clock);
		events = '0;
		request = '0;
		read_reg(`PORT_STATUS_TWO_OFFSET, 8'h80);
	endtask
	task automatic level_bits;
		base[1].csi_error = 1'b1;
		base[1].input_clock_missing = 1'b1;
		base[1].freq_integer_byte = 8'h2A;
		base[1].freq_fraction_byte = 8'h80;
		access(1'b0, `PORT_SELECT_OFFSET, 8'h01);
		read_reg(`PORT_STATUS_TWO_OFFSET, 8'h0A);
		read_reg(`FREQ_INTEGER_OFFSET, 8'h2A);
		read_reg(`FREQ_FRACTION_OFFSET, 8'h80);
		base[1] = '0;
		base[1].freq_measure_settled = 1'b1;
		read_reg(`PORT_STATUS_TWO_OFFSET, 8'h04);
		access(1'b0, `PORT_SELECT_OFFSET, 8'h04);
		read_reg(`PORT_STATUS_TWO_OFFSET, 8'h04);
		read_reg(`PORT_SELECT_OFFSET, 8'h01);
	endtask
	task automatic sensor_copy;
		@(negedge clock);
		send = 1'b1;
		port = 2'd3;
		frame = 12'hA9E;
		@(negedge clock);
		send = 1'b0;
		access(1'b0, `PORT_SELECT_OFFSET, 8'h03);
		read_reg(`ALARM_FLAGS_OFFSET, 8'h2A);
		read_reg(`VOLTAGE_LEVELS_OFFSET, 8'h36);
		access(1'b0, `PORT_SELECT_OFFSET, 8'h02);
		read_reg(`ALARM_FLAGS_OFFSET, 8'h00);
	endtask
	task automatic reset_values;
		for (int a = 8'h4C; a <= 8'h52; a++)
			read_reg(a[7:0], `STATUS_RESET);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		arst_n = 1'b0;
		request = '0;
		events = '0;
		base = '0;
		send = 1'b0;
		port = 2'd0;
		frame = '0;
		repeat (5) @(negedge clock);
		arst_n = 1'b1;
		reset_values();
		sticky_flags();
		set_wins();
		level_bits();
		sensor_copy();
		print_verdict();
	end
	initial
	begin
		#(25 * 5000);
		num_errors++;
		print_verdict();
	end
endmodule
